// file: core/regslave_pkg.sv
`default_nettype none
package regslave_pkg;

  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 32;
  localparam int NUM_REGS = 8;
  localparam int IDX_W   = 3;
  localparam int IDX_LSB = 2;
  localparam int WIDTH_W = 6;
  localparam int CNT_W   = 8;

  // Bit of the transfer-type field that marks NONSEQ or SEQ
  localparam int TRANS_ACTIVE_BIT = 1;

  // Wait cycles a held read may spend before it is ended with ERROR
  localparam int WAIT_LIMIT = 16;

  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

  // Implemented width of each register, index 0 rightmost
  localparam logic [NUM_REGS-1:0][WIDTH_W-1:0] REG_WIDTH = {
    6'h04, 6'h0C, 6'h18, 6'h20, 6'h01, 6'h08, 6'h10, 6'h20
  };

  typedef enum logic [2:0] {
    PH_RUN  = 3'b001,
    PH_WAIT = 3'b010,
    PH_ERR  = 3'b100
  } phase_t;

  // Ones in the bits a register of the given width implements
  function automatic logic [DATA_W-1:0] width_mask(
    input logic [WIDTH_W-1:0] w
  );
    width_mask = ~(32'hFFFF_FFFF << w);
  endfunction

endpackage
`default_nettype wire

// file: core/regbank_if.sv
`timescale 1ns/10ps
`default_nettype none
interface regbank_if;
  logic                                  wr_en;
  logic [regslave_pkg::IDX_W-1:0]        wr_idx;
  logic [regslave_pkg::DATA_W-1:0]       wr_data;
  logic [regslave_pkg::IDX_W-1:0]        rd_idx;
  logic [regslave_pkg::DATA_W-1:0]       rd_data;

  modport ctrl  (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
  modport store (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface
`default_nettype wire

// file: core/regbank_store.sv
`timescale 1ns/10ps
`default_nettype none
module regbank_store (
  input  wire logic  MCLK,
  input  wire logic  RESET,
  regbank_if.store   bank
);

  typedef struct packed {
    logic [regslave_pkg::NUM_REGS-1:0][regslave_pkg::DATA_W-1:0] word;
  } store_state_t;

  store_state_t s;
  store_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s = s;
    if (bank.wr_en)
    begin
      // Bits beyond the implemented width are dropped here [R06]
      next_s.word[bank.wr_idx] = bank.wr_data &
        regslave_pkg::width_mask(regslave_pkg::REG_WIDTH[bank.wr_idx]);
    end
  end

  // Upper unimplemented bits always read as zero [R01]
  assign bank.rd_data = s.word[bank.rd_idx] &
    regslave_pkg::width_mask(regslave_pkg::REG_WIDTH[bank.rd_idx]);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      s <= '0;
    else
      s <= next_s;
  end

endmodule // regbank_store
`default_nettype wire

// file: core/regslave_top.sv
// Operation
// R01: Unimplemented upper read bits return zero
// R02: Read uses control cycle then data cycle
// R03: Master presents control at first edge
// R04: Read data driven second edge, sampled third
// R05: Next control accepted during read data
// R06: Writes ignore bits beyond register width
// R07: Write data driven second, captured third edge
// R08: Next write control taken with write data
// R09: Read right after write returns new value
// R10: Same-address read after write inserts wait
// R11: Ready low third edge, high fourth edge
// R12: Over-long waited transfer ends with ERROR
// R13: Masters use only 32-bit register accesses
// R14: Transfer size never checked or errored
// R15: No hazard means zero wait states; a read taken with BANK_HOLD high still waits
`timescale 1ns/10ps
`default_nettype none
module regslave_top #(
  parameter int WAIT_LIMIT = regslave_pkg::WAIT_LIMIT
) (
  input  wire logic                              MCLK,
  input  wire logic                              RESET,
  input  wire logic                              HSEL,
  input  wire logic [regslave_pkg::ADDR_W-1:0]   HADDR,
  input  wire logic [1:0]                        HTRANS,
  input  wire logic                              HWRITE,
  input  wire logic [regslave_pkg::DATA_W-1:0]   HWDATA,
  input  wire logic                              HREADY,
  input  wire logic                              BANK_HOLD,
  output logic      [regslave_pkg::DATA_W-1:0]   HRDATA,
  output logic                                   HREADYOUT,
  output logic                                   HRESP
);

  localparam int IDX_W = regslave_pkg::IDX_W;
  localparam int CNT_W = regslave_pkg::CNT_W;
  localparam logic [CNT_W-1:0] WAIT_MAX = CNT_W'(WAIT_LIMIT);

  typedef struct packed {
    regslave_pkg::phase_t                phase;
    logic                                wr_pend;
    logic                                wr_hit;
    logic [IDX_W-1:0]                    wr_idx;
    logic                                rd_hit;
    logic [IDX_W-1:0]                    rd_idx;
    logic [CNT_W-1:0]                    wait_cnt;
    logic [regslave_pkg::DATA_W-1:0]     rdata;
    logic                                ready;
    logic                                resp;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RESET = '{
    phase:    regslave_pkg::PH_RUN,
    wr_pend:  1'b0,
    wr_hit:   1'b0,
    wr_idx:   '0,
    rd_hit:   1'b0,
    rd_idx:   '0,
    wait_cnt: '0,
    rdata:    regslave_pkg::RESET_WORD,
    ready:    1'b1,
    resp:     1'b0
  };

  ctrl_state_t s;
  ctrl_state_t next_s;
  regbank_if   bank ();

  logic take;
  logic take_rd;
  logic take_wr;
  logic hazard;
  logic hold_expired;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Only the low word offsets are mapped; anything else reads zero
  function automatic logic is_mapped(
    input logic [regslave_pkg::ADDR_W-1:0] a
  );
    is_mapped = (a[regslave_pkg::ADDR_W-1:regslave_pkg::IDX_LSB+IDX_W] == '0);
  endfunction

  function automatic logic [IDX_W-1:0] reg_index(
    input logic [regslave_pkg::ADDR_W-1:0] a
  );
    reg_index = a[regslave_pkg::IDX_LSB +: IDX_W];
  endfunction

  // Unmapped offsets return the reset word instead of bank contents
  function automatic logic [regslave_pkg::DATA_W-1:0] read_word(
    input logic                            hit,
    input logic [regslave_pkg::DATA_W-1:0] word
  );
    read_word = hit ? word : regslave_pkg::RESET_WORD;
  endfunction

  // Control is taken on the edge that ends the master's control cycle;
  // the size field is never looked at, so narrow accesses act full width
  assign take    = HSEL & HTRANS[regslave_pkg::TRANS_ACTIVE_BIT] & HREADY; // [R03] [R14]
  assign take_rd = take & ~HWRITE;
  assign take_wr = take & HWRITE;

  // Read whose word is still waiting on its write data this very edge
  assign hazard = take_rd & s.wr_pend & s.wr_hit & is_mapped(HADDR) &
                  (reg_index(HADDR) == s.wr_idx); // [R10]

  // Wait budget is spent while the bank still stalls the read
  assign hold_expired = BANK_HOLD & (s.wait_cnt >= WAIT_MAX); // [R12]

  ////////////////////////////////////////////////////////////////////////////
  // Register bank

  // HREADY is the bus-wide ready: a data phase stalled anywhere
  // must hold off both new control and the write strobe
  // Write data is captured at the edge ending its data cycle [R07]
  assign bank.wr_en   = s.wr_pend & s.wr_hit & HREADY; // [R06]
  assign bank.wr_idx  = s.wr_idx;
  assign bank.wr_data = HWDATA;
  assign bank.rd_idx  = (s.phase == regslave_pkg::PH_RUN) ?
                        reg_index(HADDR) : s.rd_idx;

  regbank_store u_store (
    .MCLK  (MCLK),
    .RESET (RESET),
    .bank  (bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transfer control

  always_comb
  begin
    next_s = s;
    // A write data cycle ends on the first edge that has HREADY high
    if (HREADY)
      next_s.wr_pend = 1'b0;
    unique case (s.phase)
      regslave_pkg::PH_RUN:
      begin
        next_s.ready = 1'b1; // [R15]
        next_s.resp  = 1'b0;
        if (take_wr)
        begin
          // Pipelined: this control rides with the previous write data
          next_s.wr_pend = 1'b1; // [R08]
          next_s.wr_hit  = is_mapped(HADDR);
          next_s.wr_idx  = reg_index(HADDR);
        end
        if (take_rd)
        begin
          next_s.rd_hit = is_mapped(HADDR);
          next_s.rd_idx = reg_index(HADDR);
          if (hazard || BANK_HOLD)
          begin
            // Old contents must not be returned, so hold one cycle
            next_s.ready    = 1'b0; // [R11] [R09]
            next_s.wait_cnt = CNT_W'(1);
            next_s.phase    = regslave_pkg::PH_WAIT;
          end
          else
          begin
            // Data leaves on the edge that took the control [R02] [R04] [R05]
            next_s.rdata = read_word(is_mapped(HADDR), bank.rd_data); // [R01]
          end
        end
      end
      regslave_pkg::PH_WAIT:
      begin
        if (hold_expired)
        begin
          // First of the two ERROR cycles: ready still low [R12]
          next_s.resp  = 1'b1;
          next_s.phase = regslave_pkg::PH_ERR;
        end
        else if (BANK_HOLD)
        begin
          // Still stalled: one more wait cycle is spent
          next_s.wait_cnt = s.wait_cnt + CNT_W'(1);
        end
        else
        begin
          // The write landed last edge, so the bank now holds new data [R09]
          next_s.rdata = read_word(s.rd_hit, bank.rd_data); // [R11] [R01]
          next_s.ready = 1'b1;
          next_s.phase = regslave_pkg::PH_RUN;
        end
      end
      regslave_pkg::PH_ERR:
      begin
        // Second ERROR cycle runs in PH_RUN, so new control is taken
        next_s.ready = 1'b1; // [R12]
        next_s.resp  = 1'b1;
        next_s.phase = regslave_pkg::PH_RUN;
      end
      default:
      begin
        // An illegal phase code recovers to idle with ready high
        next_s = CTRL_RESET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous reset leaves the bus idle: ready high, OKAY
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      s <= CTRL_RESET;
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the state flops

  assign HRDATA    = s.rdata;
  assign HREADYOUT = s.ready;
  assign HRESP     = s.resp;

endmodule // regslave_top
`default_nettype wire

// file: verif/regslave_properties.sv
`timescale 1ns/10ps
`default_nettype none
module regslave_chk #(
  parameter int WAIT_LIMIT = 16
) (
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic        HREADY,
  input  wire logic        BANK_HOLD,
  input  wire logic [31:0] HRDATA,
  input  wire logic        HREADYOUT,
  input  wire logic        HRESP
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  logic        taken;
  logic        hz;
  logic        wp;
  logic [31:0] wa;
  logic [2:0]  ridx;
  int          lows;
  assign taken = HSEL && HTRANS[1] && HREADY;
  // Unmapped words always read zero, so they need no wait
  assign hz = taken && !HWRITE && wp && HADDR == wa &&
              HADDR[31:5] == 27'h0;
  function automatic logic [31:0] msk(input logic [5:0] w);
    msk = (w > 6'h1F) ? 32'hFFFF_FFFF : ~(32'hFFFF_FFFF << w);
  endfunction
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      wp <= 1'b0;
      wa <= 32'h0;
      ridx <= 3'h0;
      lows <= 0;
    end
    else
    begin
      wp <= taken && HWRITE;
      wa <= HADDR;
      ridx <= HADDR[4:2];
      lows <= HREADYOUT ? 0 : lows + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  sequence s_wait1;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  sequence s_err;
    !HREADYOUT && HRESP ##1 HREADYOUT && HRESP ##1 !HRESP;
  endsequence
  AST_IDLE_AFTER_RESET: assert property (
    $fell(RESET) |-> HREADYOUT && !HRESP && HRDATA == 32'h0)
    else $error("bus not idle after reset");
  AST_READ_UPPER_ZERO: assert property (
    taken && !HWRITE && !hz && !BANK_HOLD
    |=> (HRDATA & ~msk(regslave_pkg::REG_WIDTH[ridx])) == 32'h0)
    else $error("unimplemented read bits not zero");
  AST_READ_NO_WAIT: assert property (
    taken && !HWRITE && !hz && !BANK_HOLD |=> HREADYOUT && !HRESP)
    else $error("plain read was waited");
  AST_WRITE_NO_WAIT: assert property (
    taken && HWRITE |=> HREADYOUT)
    else $error("write data phase was waited");
  AST_WRITE_KEEPS_RDATA: assert property (
    taken && HWRITE |=> $stable(HRDATA))
    else $error("read data moved on a write");
  AST_HAZARD_WAIT: assert property (
    hz && !BANK_HOLD |=> s_wait1)
    else $error("same address read without one wait");
  AST_ERROR_SHAPE: assert property (
    $rose(HRESP) |-> s_err)
    else $error("error response not two cycles");
  AST_WAIT_BOUND: assert property (
    lows <= WAIT_LIMIT + 2)
    else $error("waited transfer never ended");
endmodule // regslave_chk
bind regslave_top regslave_chk #(.WAIT_LIMIT(WAIT_LIMIT)) regslave_chk_inst (
  .MCLK(MCLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .BANK_HOLD(BANK_HOLD), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP));
`default_nettype wire

// file: verif/bus_master.sv
`timescale 1ns/10ps
`default_nettype none
module bus_master (
  input  wire logic        clk,
  output logic             sel,
  output logic [31:0]      addr,
  output logic [1:0]       trans,
  output logic             wr,
  output logic [31:0]      wdata,
  input  wire logic        rdy,
  input  wire logic [31:0] rdata,
  input  wire logic        resp
);
  initial {sel, addr, trans, wr, wdata} = '0;
  // Only whole words; there is no size to narrow
  task automatic op(input logic w, input logic [31:0] a, d,
                    input logic two, input logic [31:0] a2,
                    output logic [31:0] r, output int wt,
                    output logic rs);
    @(negedge clk);
    {sel, trans, wr, addr} = {1'b1, 2'h2, w, a};
    // Control stands until an edge with ready high takes it
    while (!rdy) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    wdata = d;
    if (two)
    begin
      {wr, addr} = {1'b0, a2};
      while (!rdy) @(negedge clk);
      @(posedge clk);
      @(negedge clk);
    end
    // Released address is inverted so a stale value never looks valid
    {sel, trans, addr} = {1'b0, 2'h0, ~addr};
    wt = 0;
    while (!rdy && wt < 64)
    begin
      @(negedge clk);
      wt++;
    end
    r = rdata;
    rs = resp;
    @(posedge clk);
    @(negedge clk);
    wdata = ~wdata;
  endtask
endmodule // bus_master
`default_nettype wire

// file: verif/regslave_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module regslave_top_tb;
  logic        MCLK = 1'b0;
  logic        RESET = 1'b1;
  logic        BANK_HOLD = 1'b0;
  logic        sel, wr, rdy, resp, rs;
  logic [1:0]  trans;
  logic [31:0] addr, wdata, rdata, r;
  int          wt;
  int          n_fail = 0;
  int          n_checks = 0;
  // Short limit keeps the timeout case brief
  localparam int WAIT_CAP = 2;
  regslave_top #(.WAIT_LIMIT(WAIT_CAP)) regslave_top_inst (
    .MCLK(MCLK), .RESET(RESET), .HSEL(sel), .HADDR(addr),
    .HTRANS(trans), .HWRITE(wr), .HWDATA(wdata), .HREADY(rdy),
    .BANK_HOLD(BANK_HOLD), .HRDATA(rdata), .HREADYOUT(rdy),
    .HRESP(resp));
  bus_master bus_master_inst (
    .clk(MCLK), .sel(sel), .addr(addr), .trans(trans), .wr(wr),
    .wdata(wdata), .rdy(rdy), .rdata(rdata), .resp(resp));
  initial forever #50 MCLK = ~MCLK;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic go(input logic w, input logic [31:0] a, d,
                    input logic two, input logic [31:0] a2);
    bus_master_inst.op(w, a, d, two, a2, r, wt, rs);
    // A transfer that never completed counts against the run
    if (wt >= 64)
      chk(32'(wt), 32'h0);
  endtask
  task automatic t_reset;
    chk(rdata, 32'h0);
    chk({30'h0, rdy, resp}, 32'h2);
    $display("t_reset done");
  endtask
  task automatic t_widths;
    logic [5:0] w;
    for (int i = 0; i < 9; i++)
    begin
      w = (i < 8) ? regslave_pkg::REG_WIDTH[i] : 6'h00;
      go(1'b1, 32'(i * 4), 32'hFFFF_FFFF, 1'b0, 32'h0);
      go(1'b0, 32'(i * 4), 32'h0, 1'b0, 32'h0);
      chk(r, (w == 6'h20) ? 32'hFFFF_FFFF : (32'h1 << w) - 32'h1);
      chk(32'(wt), 32'h0);
      chk({31'h0, rs}, 32'h0);
    end
    $display("t_widths done");
  endtask
  task automatic t_pipe;
    go(1'b1, 32'h0, 32'hA5C3_5A3C, 1'b1, 32'h0);
    chk(r, 32'hA5C3_5A3C);
    chk(32'(wt), 32'h1);
    go(1'b1, 32'h4, 32'h1234_5678, 1'b1, 32'h10);
    chk(r, 32'hFFFF_FFFF);
    chk(32'(wt), 32'h0);
    go(1'b0, 32'h4, 32'h0, 1'b0, 32'h0);
    chk(r, 32'h0000_5678);
    chk(32'(wt), 32'h0);
    $display("t_pipe done");
  endtask
  task automatic t_timeout;
    @(negedge MCLK) BANK_HOLD = 1'b1;
    go(1'b0, 32'h8, 32'h0, 1'b0, 32'h0);
    chk({31'h0, rs}, 32'h1);
    chk(32'(wt), 32'(WAIT_CAP + 1));
    @(negedge MCLK) BANK_HOLD = 1'b0;
    $display("t_timeout done");
  endtask
  initial
  begin
    repeat (4) @(posedge MCLK);
    @(negedge MCLK) RESET = 1'b0;
    t_reset;
    t_widths;
    t_pipe;
    t_timeout;
    wrap_up;
  end
  initial
  begin
    #200000;
    n_fail++;
    wrap_up;
  end
endmodule // regslave_top_tb
`default_nettype wire
